/* hw/cst_map.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion from the clocked serial transfer core
`ifndef CST_MAP_SVH
`define CST_MAP_SVH

// avalon byte offsets
`define CST_CTRL_OFS 6'h00
`define CST_STAT_OFS 6'h04
`define CST_BUF_OFS 6'h20

// control field positions
`define CST_CTRL_START 0
`define CST_CTRL_MODE_LO 1
`define CST_CTRL_MODE_HI 2
`define CST_CTRL_NIB 3
`define CST_CTRL_EXT 4
`define CST_CTRL_WORDS_LO 5
`define CST_CTRL_WORDS_HI 7

// status field positions
`define CST_STAT_ACTIVE 7
`define CST_STAT_SHIFT 6
`define CST_STAT_PTR_HI 2

// reset values
`define CST_CTRL_RST 8'h00
`define CST_SCK_IDLE 1'b1
`define CST_SO_RST 1'b1

// timing
`define CST_CLK_NS 100
`define CST_SCK_HALF_NS 400
`define CST_SCK_HALF_CYC ((`CST_SCK_HALF_NS) / (`CST_CLK_NS))

`endif

/* hw/cst_pkg.sv */
// types of the clocked serial transfer block
// assumes cst_map.svh for the numeric constants
package cst_pkg;

  typedef enum logic [2:0] {
    CST_IDLE  = 3'b000,
    CST_LOAD  = 3'b001,
    CST_SHIFT = 3'b010,
    CST_WAIT  = 3'b011,
    CST_DONE  = 3'b100
  } cst_state_t;

  typedef enum logic [1:0] {
    CST_TX   = 2'b00,
    CST_RX   = 2'b01,
    CST_TXRX = 2'b10,
    CST_RSVD = 2'b11
  } cst_mode_t;

  typedef struct packed {
    cst_state_t st;
    logic start;
    cst_mode_t mode;
    logic nib;
    logic ext;
    logic [2:0] words;
    logic [7:0][7:0] buf_mem;
    logic [7:0] pend;
    logic [2:0] ptr;
    logic [2:0] bitn;
    logic [7:0] txsh;
    logic [7:0] rxsh;
    logic [3:0] cnt;
    logic sck;
    logic so;
    logic active;
    logic rseen;
    logic wseen;
    logic irq;
    logic ack;
    logic [31:0] rdata;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic si_s1;
    logic si_s2;
  } cst_regs_t;

endpackage

/* hw/cst_serial.sv */
// clocked serial transfer core: 8-word buffer, tx, rx and tx/rx modes
// assumes avalon-mm master on clk, external pins synchronised here
//
// Functional notes
// RL1: tx starts only when software writes start bit to one.
// RL2: output data bit by bit with serial clock, lsb first.
// RL3: after a word's last bit, next buffer word loads into shifter.
// RL4: tx raises completion pulse after programmed word count is sent.
// RL5: internal clock tx stops clock and waits if no new data.
// RL6: any single buffer write releases the tx wait.
// RL7: writes outside the active buffer also release the wait.
// RL8: with external clock, software writes next word before it shifts.
// RL9: software clears start bit after final bit to end transmission.
// RL10: active flag at status bit 7 clears when transfer completes.
// RL11: external clock: late start clear gives dummy word, then end.
// RL12: rx after start shifts input bits and stores each word.
// RL13: rx raises completion pulse when programmed word count received.
// RL14: internal rx waits when unread data remain and nothing read.
// RL15: reads outside active buffer also release the rx wait.
// RL16: external rx drops word and cancels when previous unread.
// RL17: start clear in rx stores current word, ends, clears active.
// RL18: changing mode discards buffer contents.
// RL19: tx/rx drives on leading edge, samples on trailing, 8-bit words.
// RL20: software reads received words before writing next tx words.
// RL21: internal tx/rx waits until both read and write happened.
// RL22: external tx/rx: software reads and writes before next shift.
// RL23: active flag reads one during transfer, zero after end.
// RL24: up to 8 words per buffer cycle set by word count field.
// RL25: leading edge is the falling edge of the clock pin.
// RL26: 4-bit transfers use low nibble, upper bits cleared on receive.
// RL27: active flag sets at start write and holds until end handling.
`include "cst_map.svh"
`timescale 1ns/1ps
`default_nettype none

module cst_serial (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // serial pins
  output logic serial_out_pin,
  input wire logic serial_in_pin,
  input wire logic shift_clock_pin_in,
  output logic shift_clock_pin_out,
  output logic shift_clock_pin_oe,
  // status
  output logic transfer_complete_irq,
  output logic transfer_active_flag
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  cst_pkg::cst_regs_t r;
  cst_pkg::cst_regs_t n;

  logic tx_en;
  logic rx_en;
  logic fall_ev;
  logic rise_ev;
  logic wend;
  logic wrap;
  logic store_ok;
  logic need_wait;
  logic acc;
  logic acc_wr;
  logic acc_rd;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_buf;
  logic [2:0] bidx;
  logic [2:0] last_bit;
  logic [7:0] rx_word;
  logic [7:0] stat_val;
  logic [7:0] ctrl_val;

  assign tx_en = (r.mode != cst_pkg::CST_RX);
  assign rx_en = (r.mode != cst_pkg::CST_TX);
  assign last_bit = (r.nib && r.mode != cst_pkg::CST_TXRX) ? 3'h3 : 3'h7;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  assign waitrequest = (read | write) & ~r.ack;
  assign acc = (read | write) & r.ack;
  assign acc_wr = acc & write & byteenable[0];
  assign acc_rd = acc & read;
  assign hit_ctrl = (address == `CST_CTRL_OFS);
  assign hit_stat = (address == `CST_STAT_OFS);
  assign hit_buf = address[5] && (address[1:0] == 2'h0);
  assign bidx = address[4:2];
  assign ctrl_val = {r.words, r.ext, r.nib, r.mode, r.start};
  assign stat_val = {r.active, (r.st == cst_pkg::CST_SHIFT), 3'h0, r.ptr};

  // ------------------------------------------------------------
  // combinational next state
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    n.irq = 1'b0;
    fall_ev = 1'b0;
    rise_ev = 1'b0;
    wend = 1'b0;
    wrap = 1'b0;
    store_ok = 1'b1;
    rx_word = {serial_in_pin_s(r), r.rxsh[7:1]};
    need_wait = 1'b0;

    // pin synchronisers
    n.sck_s1 = shift_clock_pin_in;
    n.sck_s2 = r.sck_s1;
    n.sck_s3 = r.sck_s2;
    n.si_s1 = serial_in_pin;
    n.si_s2 = r.si_s1;

    // wait condition per mode
    case (r.mode)
      cst_pkg::CST_TX: need_wait = (r.ptr == 3'h0) && !r.wseen; // RL5
      cst_pkg::CST_RX: need_wait = r.pend[r.ptr] && !r.rseen; // RL14
      default: need_wait = (r.ptr == 3'h0) && !(r.rseen && r.wseen); // RL21
    endcase

    case (r.st)
      cst_pkg::CST_IDLE: begin
        n.sck = `CST_SCK_IDLE;
      end
      cst_pkg::CST_LOAD: begin
        n.txsh = r.buf_mem[r.ptr]; // RL3
        n.bitn = 3'h0;
        n.rxsh = 8'h00;
        n.cnt = 4'h0;
        n.sck = `CST_SCK_IDLE;
        n.st = cst_pkg::CST_SHIFT;
      end
      cst_pkg::CST_SHIFT: begin
        if (r.ext) begin
          fall_ev = r.sck_s3 & ~r.sck_s2;
          rise_ev = ~r.sck_s3 & r.sck_s2;
          if (fall_ev) begin
            n.cnt = 4'h1; // ext: first leading edge of the word seen
          end
        end else if (r.cnt == 4'(`CST_SCK_HALF_CYC - 1)) begin
          n.cnt = 4'h0;
          n.sck = ~r.sck;
          fall_ev = r.sck;
          rise_ev = ~r.sck;
        end else begin
          n.cnt = r.cnt + 4'h1;
        end
        if (fall_ev && tx_en) begin
          n.so = r.txsh[r.bitn]; // RL2 RL19 RL25
        end
        if (rise_ev) begin
          n.rxsh = rx_word; // RL19
          n.bitn = r.bitn + 3'h1;
          wend = (r.bitn == last_bit);
        end
        if (wend) begin
          if (rx_en) begin
            store_ok = !(r.ext && r.pend[r.ptr] && !r.rseen); // RL16
            if (store_ok) begin
              n.buf_mem[r.ptr] = (last_bit == 3'h3) ? {4'h0, rx_word[7:4]} : rx_word; // RL12 RL26
              n.pend[r.ptr] = 1'b1;
            end
          end
          wrap = (r.ptr == r.words); // RL24
          n.ptr = wrap ? 3'h0 : r.ptr + 3'h1;
          if (wrap) begin
            n.irq = 1'b1; // RL4 RL13
            n.rseen = 1'b0;
            n.wseen = 1'b0;
          end
          if (!store_ok || !r.start) begin
            n.st = cst_pkg::CST_DONE; // RL9 RL11 RL16 RL17
          end else if (r.ext) begin
            n.st = cst_pkg::CST_LOAD; // RL8 RL22
          end else begin
            n.st = cst_pkg::CST_WAIT;
          end
        end
        // ext: start cleared before the word's first leading edge
        if (r.ext && !r.start && r.cnt == 4'h0 && !fall_ev) begin
          n.st = cst_pkg::CST_DONE; // RL11
        end
      end
      cst_pkg::CST_WAIT: begin
        n.sck = `CST_SCK_IDLE;
        if (!r.start) begin
          n.st = cst_pkg::CST_DONE;
        end else if (!need_wait) begin
          n.st = cst_pkg::CST_LOAD; // RL6 RL7 RL15 RL20
        end
      end
      cst_pkg::CST_DONE: begin
        n.active = 1'b0; // RL10 RL23
        n.start = 1'b0;
        n.sck = `CST_SCK_IDLE;
        n.st = cst_pkg::CST_IDLE;
      end
      default: begin
        n.st = cst_pkg::CST_IDLE;
      end
    endcase

    // bus side, after the serial side so a bus event wins, except a read's pend clear against a store in the same cycle
    n.ack = (read | write) & ~r.ack;
    if ((read | write) && !r.ack) begin
      if (hit_ctrl) begin
        n.rdata = {24'h000000, ctrl_val};
      end else if (hit_stat) begin
        n.rdata = {24'h000000, stat_val};
      end else if (hit_buf) begin
        n.rdata = {24'h000000, r.buf_mem[bidx]};
      end else begin
        n.rdata = 32'h00000000;
      end
    end
    if (acc_rd && hit_buf) begin
      if (!(wend && rx_en && store_ok && r.ptr == bidx)) begin
        n.pend[bidx] = 1'b0; // a store in the same cycle wins
      end
      n.rseen = 1'b1; // RL14 RL15
    end
    if (acc_wr && hit_buf) begin
      n.buf_mem[bidx] = writedata[7:0];
      n.wseen = 1'b1; // RL6 RL7
    end
    if (acc_wr && hit_ctrl) begin
      n.start = writedata[`CST_CTRL_START];
      if (r.st == cst_pkg::CST_IDLE) begin
        n.mode = cst_pkg::cst_mode_t'(writedata[`CST_CTRL_MODE_HI:`CST_CTRL_MODE_LO]);
        n.nib = writedata[`CST_CTRL_NIB];
        n.ext = writedata[`CST_CTRL_EXT];
        n.words = writedata[`CST_CTRL_WORDS_HI:`CST_CTRL_WORDS_LO];
        if (writedata[`CST_CTRL_MODE_HI:`CST_CTRL_MODE_LO] != r.mode) begin
          n.buf_mem = '0; // RL18
          n.pend = 8'h00;
        end
        if (writedata[`CST_CTRL_START]) begin
          n.active = 1'b1; // RL1 RL27
          n.ptr = 3'h0;
          n.rseen = 1'b0;
          n.wseen = 1'b0;
          n.st = cst_pkg::CST_LOAD;
        end
      end
    end
  end

  // synchronised serial input bit
  function automatic logic serial_in_pin_s(input cst_pkg::cst_regs_t v);
    serial_in_pin_s = v.si_s2;
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.sck <= `CST_SCK_IDLE;
      r.so <= `CST_SO_RST;
      r.sck_s1 <= `CST_SCK_IDLE;
      r.sck_s2 <= `CST_SCK_IDLE;
      r.sck_s3 <= `CST_SCK_IDLE;
    end else if (ce) begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign readdata = r.rdata;
  assign serial_out_pin = r.so;
  assign shift_clock_pin_out = r.sck;
  assign shift_clock_pin_oe = ~r.ext;
  assign transfer_complete_irq = r.irq;
  assign transfer_active_flag = r.active;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_start_wr;
    ce && acc_wr && hit_ctrl && writedata[0] && r.st == cst_pkg::CST_IDLE;
  endsequence

  sequence s_tx_wait_wr;
    ce && r.st == cst_pkg::CST_WAIT && r.mode == cst_pkg::CST_TX && r.start &&
      !r.ext && need_wait && acc_wr && hit_buf;
  endsequence

  sequence s_stop_end;
    ce && wend && !r.start;
  endsequence

  property p_start_active;
    s_start_wr |=> r.active && r.st == cst_pkg::CST_LOAD;
  endproperty
  a_start_active: assert property (p_start_active) else $error("start did not set active"); // RL27

  property p_done_clear;
    ce && r.st == cst_pkg::CST_DONE |=> !r.active && r.st == cst_pkg::CST_IDLE;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("active not cleared at end"); // RL10

  property p_irq_pulse;
    ce && r.irq |-> r.ptr == 3'h0 ##1 !r.irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("completion pulse malformed"); // RL13

  property p_wait_sck;
    r.st == cst_pkg::CST_WAIT && ce |=> r.sck;
  endproperty
  a_wait_sck: assert property (p_wait_sck) else $error("serial clock runs during wait"); // RL5

  property p_wait_release;
    s_tx_wait_wr ##1 ce |=> r.st == cst_pkg::CST_LOAD;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("write did not release wait"); // RL6

  property p_mode_clear;
    ce && acc_wr && hit_ctrl && r.st == cst_pkg::CST_IDLE &&
      writedata[2:1] != r.mode |=> r.pend == 8'h00 && r.buf_mem == '0;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode change kept buffer"); // RL18

  property p_ext_cancel;
    ce && wend && rx_en && r.ext && r.pend[r.ptr] && !r.rseen |=> r.st == cst_pkg::CST_DONE;
  endproperty
  a_ext_cancel: assert property (p_ext_cancel) else $error("overrun did not cancel"); // RL16

  property p_rx_store;
    ce && wend && rx_en && store_ok |=> r.pend[$past(r.ptr)];
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("received word not stored"); // RL12

  property p_stop;
    s_stop_end |=> r.st == cst_pkg::CST_DONE ##1 (!r.active || !$past(ce));
  endproperty
  a_stop: assert property (p_stop) else $error("start clear did not end transfer"); // RL17

  property p_ext_cut;
    ce && r.st == cst_pkg::CST_SHIFT && r.ext && !r.start && r.cnt == 4'h0 &&
      !(r.sck_s3 && !r.sck_s2) |=> r.st == cst_pkg::CST_DONE;
  endproperty
  a_ext_cut: assert property (p_ext_cut) else $error("cut frame did not end"); // RL11

endmodule

`default_nettype wire

/* verif/cst_peer.sv */
// far-side serial peripheral model for the clocked serial transfer core
// assumes the bench resolves the clock pin and pulses load before a frame
`timescale 1ns/1ps
`default_nettype none

module cst_peer (
  // serial pins
  input wire logic sck,
  input wire logic so,
  output logic si,
  // bench control
  input wire logic [7:0] tx_byte,
  input wire logic load,
  input wire logic ext_run,
  output logic ext_sck,
  // captured stream
  output logic [15:0] rx_word
);
  logic [7:0] tsh;

  initial begin
    si = 1'b1;
    ext_sck = 1'b1;
    rx_word = 16'h0000;
    tsh = 8'h00;
  end

  // -----------------------------
  // external clock, within frames only
  // -----------------------------
  always begin
    wait (ext_run === 1'b1);
    #423 ext_sck = 1'b0;
    #377 ext_sck = 1'b1;
  end

  // -----------------------------
  // drive on falling, capture on rising
  // -----------------------------
  always @(negedge sck or posedge load) begin
    if (load) begin
      tsh <= tx_byte;
    end else begin
      si <= tsh[0];
      tsh <= {~tsh[0], tsh[7:1]};
    end
  end

  always @(posedge sck) begin
    rx_word <= {so, rx_word[15:1]};
  end
endmodule

`default_nettype wire

/* verif/tb_cst_serial.sv */
// self-checking bench for the clocked serial transfer core
// assumes cst_serial and cst_peer compiled before it
`timescale 1ns/1ps
`default_nettype none

module tb_cst_serial;
  logic clk, reset, rd, wr, irq, act, so, si, sck_o, sck_oe, wq, ext_run, ext_sck, ld;
  logic [5:0] addr;
  logic [31:0] wd, rdat;
  logic [7:0] ptx, b, v, t;
  logic [7:0] mc [3] = '{8'h03, 8'h0B, 8'h05};
  logic [15:0] prx;
  wire sck_w;
  int num_errors = 0;
  int check_count = 0;

  assign sck_w = sck_oe ? sck_o : ext_sck;

  cst_serial dut (.clk(clk), .reset(reset), .ce(1'b1), .address(addr), .read(rd),
    .write(wr), .writedata(wd), .byteenable(4'hF), .readdata(rdat), .waitrequest(wq),
    .serial_out_pin(so), .serial_in_pin(si), .shift_clock_pin_in(sck_w),
    .shift_clock_pin_out(sck_o), .shift_clock_pin_oe(sck_oe),
    .transfer_complete_irq(irq), .transfer_active_flag(act));

  cst_peer peer (.sck(sck_w), .so(so), .si(si), .tx_byte(ptx), .load(ld),
    .ext_run(ext_run), .ext_sck(ext_sck), .rx_word(prx));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // -----------------------------
  // shared tasks
  // -----------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic report_and_stop;
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= {24'h000000, d};
    wr <= 1'b1;
    do @(posedge clk); while (wq !== 1'b0);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    do @(posedge clk); while (wq !== 1'b0);
    d = rdat[7:0];
    rd <= 1'b0;
  endtask

  task automatic wait_irq;
    for (int n = 0; n < 400 && irq !== 1'b1; n++) @(negedge clk);
    chk("irq", 8'h01, {7'h00, irq});
  endtask

  task automatic wait_idle;
    for (int n = 0; n < 400 && act !== 1'b0; n++) @(negedge clk);
    chk("active", 8'h00, {7'h00, act});
  endtask

  task automatic load_peer(input logic [7:0] x);
    ptx <= x;
    @(posedge clk);
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
  endtask

  // -----------------------------
  // main sequence
  // -----------------------------
  initial begin
    {rd, wr, ld, ext_run} = 4'h0;
    addr = 6'h00;
    wd = 32'h00000000;
    ptx = 8'h00;
    reset = 1'b1;
    void'($urandom(32'h1F488DAF));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("pins", 8'h06, {5'h00, so, sck_o, act});
    rd_reg(6'h04, v);
    chk("status", 8'h00, v);
    rd_reg(6'h08, v);
    chk("unmapped", 8'h00, v);
    // internal tx, wait, release by outside write
    b = 8'($urandom);
    wr_reg(6'h20, b);
    wr_reg(6'h00, 8'h01);
    rd_reg(6'h04, v);
    chk("busy", 8'h01, {7'h00, v[7]});
    wait_irq;
    chk("tx byte", b, prx[15:8]);
    repeat (30) begin
      @(negedge clk);
      chk("tx wait", 8'h01, {7'h00, sck_o});
    end
    wr_reg(6'h3C, 8'($urandom));
    wait_irq;
    chk("tx again", b, prx[15:8]);
    wr_reg(6'h00, 8'h00);
    wait_idle;
    // rx 8-bit, rx 4-bit, tx/rx
    for (int m = 0; m < 3; m++) begin
      b = 8'($urandom);
      t = 8'($urandom);
      load_peer(b);
      wr_reg(6'h00, mc[m] & 8'hFE);
      wr_reg(6'h20, t);
      wr_reg(6'h00, mc[m]);
      wait_irq;
      if (m == 0) begin
        rd_reg(6'h3C, v);
        wait_irq;
      end
      wr_reg(6'h00, mc[m] & 8'hFE);
      wait_idle;
      rd_reg(6'h20, v);
      chk("rx byte", (m == 1) ? {4'h0, b[3:0]} : ((m == 0) ? ~b : b), v);
      if (m == 2) chk("txrx out", t, prx[15:8]);
    end
    wr_reg(6'h00, 8'h00);
    rd_reg(6'h20, v);
    chk("discard", 8'h00, v);
    // external clock tx
    b = 8'($urandom);
    wr_reg(6'h00, 8'h10);
    wr_reg(6'h20, b);
    wr_reg(6'h00, 8'h11);
    chk("oe", 8'h00, {7'h00, sck_oe});
    ext_run <= 1'b1;
    repeat (62) @(posedge clk);
    ext_run <= 1'b0;
    wait_irq;
    wr_reg(6'h00, 8'h10);
    wait_idle;
    chk("ext tx", b, prx[15:8]);
    report_and_stop;
  end

  initial begin
    #2000000;
    num_errors++;
    report_and_stop;
  end
endmodule

`default_nettype wire
